// File: inc/csc_params.svh
// constants for the clock source and start-up controller
// assumes inclusion by bare name from the package and from the design modules
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// fuse field widths and factory settings (1 = unprogrammed, 0 = programmed)
`define CSC_SRC_SEL_W        4
`define CSC_SUT_W            2
`define CSC_MODE_W           3
`define CSC_DEFAULT_SRC_SEL  4'h2
`define CSC_DEFAULT_SUT      2'h2
`define CSC_DEFAULT_DIV8     1'h0

// time-out lengths in watchdog oscillator cycles
`define CSC_TOUT_NONE        16'h0000
`define CSC_TOUT_SHORT       16'h0200
`define CSC_TOUT_LONG        16'h2000

// stabilisation lengths in selected oscillator cycles
`define CSC_STAB_EXT         16'h0006
`define CSC_STAB_258         16'h0102
`define CSC_STAB_1K          16'h0400
`define CSC_STAB_16K         16'h4000
`define CSC_STAB_32K         16'h8000

// system clock prescaler when the divide-by-eight fuse is programmed
`define CSC_DIV8_LAST        3'h7

// width of the cycle counters
`define CSC_CNT_W            16

`endif

// File: inc/csc_pkg.sv
// types shared by the clock source and start-up controller
// assumes csc_params.svh sits on the include path
`include "csc_params.svh"

package csc_pkg;

    // clock source family decoded from the source select fuse
    typedef enum logic [2:0] {
        SRC_LOW_POWER_XTAL = 3'h0,
        SRC_FULL_SWING_XTAL = 3'h1,
        SRC_LOW_FREQ_XTAL = 3'h2,
        SRC_RC_128K = 3'h3,
        SRC_RC_CAL = 3'h4,
        SRC_EXTERNAL = 3'h5,
        SRC_RESERVED = 3'h6
    } csc_source_t;

    // requested sleep mode, active means no sleep
    typedef enum logic [`CSC_MODE_W-1:0] {
        MODE_ACTIVE = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_ADC_NR = 3'h2,
        MODE_POWER_SAVE = 3'h3,
        MODE_POWER_DOWN = 3'h4,
        MODE_STANDBY = 3'h5,
        MODE_EXT_STANDBY = 3'h6
    } csc_mode_t;

    // start-up sequencer, one-hot
    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_TIMEOUT = 5'h02,
        ST_STABILISE = 5'h04,
        ST_RUN = 5'h08,
        ST_SLEEP = 5'h10
    } csc_state_t;

endpackage

// File: rtl/csc_clock_control.sv
// clock source decode, domain gating and start-up sequencing
// assumes all inputs synchronous to clk; oscillator ticks arrive as strobes
`timescale 1ns/100ps
`include "csc_params.svh"

// Behaviour
// - core domain off stops core, registers, stack
// - peripheral domain feeds timers, serial, sync interrupts
// - selected interrupts detected while peripheral clock halted
// - serial start and address match wake always
// - flash domain gated together with core domain
// - async timer domain runs during sleep, except in power-down and standby
// - converter domain separate, runs in noise reduction
// - domains halted per sleep mode to save power
// - source select fuse decodes clock source family
// - fuse zero means programmed; defaults give 1 MHz
// - time-out follows release of other reset sources
// - time-out counts 0, 512 or 8192 watchdog cycles
// - oscillator tick counter holds reset then releases
// - stabilisation 6 up to 32K oscillator cycles
// - reset start applies time-out then stabilisation
// - power-save or power-down wake skips time-out
// - brown-out holds reset; time-out may be zero
// - low-power crystal stabilisation 258, 1K or 16K
module csc_clock_control (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [`CSC_SRC_SEL_W-1:0]  clock_source_select,
    input  wire logic [`CSC_SUT_W-1:0]      startup_time_select,
    input  wire logic                       divide_by_eight_fuse,
    input  wire logic                       otherResetActive,
    input  wire logic                       brownoutEnable,
    input  wire logic                       brownoutLow,
    input  wire logic                       watchdogOscTick,
    input  wire logic                       oscTick,
    input  wire logic [`CSC_MODE_W-1:0]     sleepMode,
    input  wire logic                       sleepRequest,
    input  wire logic                       asyncTimerSelect,
    input  wire logic                       asyncIntPin,
    input  wire logic                       syncIntEvent,
    input  wire logic                       serialStartDetect,
    input  wire logic                       twoWireAddrMatch,
    input  wire logic                       asyncTimerWake,
    input  wire logic                       converterDone,
    output logic                            internalReset,
    output logic                            core_clock,
    output logic                            flash_clock,
    output logic                            peripheral_clock,
    output logic                            async_timer_clock,
    output logic                            converter_clock,
    output logic                            systemTick,
    output logic                            sleeping,
    output logic                            reservedSource,
    output logic                            unsafeTimeout
);

    // decode the source select fuse into a family
    function automatic csc_pkg::csc_source_t decodeSource(
        input logic [`CSC_SRC_SEL_W-1:0] sel
    );
        casez (sel)
            4'b1???: decodeSource = csc_pkg::SRC_LOW_POWER_XTAL;
            4'b011?: decodeSource = csc_pkg::SRC_FULL_SWING_XTAL;
            4'b010?: decodeSource = csc_pkg::SRC_LOW_FREQ_XTAL;
            4'h3:    decodeSource = csc_pkg::SRC_RC_128K;
            4'h2:    decodeSource = csc_pkg::SRC_RC_CAL;
            4'h0:    decodeSource = csc_pkg::SRC_EXTERNAL;
            default: decodeSource = csc_pkg::SRC_RESERVED;
        endcase
    endfunction

    // time-out in watchdog cycles for a start-up select value
    function automatic logic [`CSC_CNT_W-1:0] plainTimeout(
        input logic [`CSC_SUT_W-1:0] sut
    );
        case (sut)
            2'h0:    plainTimeout = `CSC_TOUT_NONE;
            2'h1:    plainTimeout = `CSC_TOUT_SHORT;
            default: plainTimeout = `CSC_TOUT_LONG;
        endcase
    endfunction

    csc_pkg::csc_source_t source;       // decoded clock family
    csc_pkg::csc_mode_t   mode;         // requested sleep mode
    csc_pkg::csc_state_t  state_q;      // sequencer state
    csc_pkg::csc_state_t  state_d;      // next sequencer state
    logic [3:0]           xtalSel;      // low select bit with start-up select
    logic [`CSC_CNT_W-1:0] timeoutCycles;   // selected time-out length
    logic [`CSC_CNT_W-1:0] stabCycles;      // selected stabilisation length
    logic                 resetCause;   // any other reset source active
    logic                 wakeEvent;    // any wake source in the current mode
    logic                 startTimeout; // load pulse for the time-out counter
    logic                 startStab;    // load pulse for the stabilisation counter
    logic                 timeoutDone;  // time-out counter reached its target
    logic                 stabDone;     // stabilisation counter reached its target
    logic                 fromReset_q;  // stabilising after reset, not after wake
    logic [2:0]           divCount_q;   // divide-by-eight prescaler
    logic                 asyncPin_q;   // pin level seen on the ungated clock
    logic                 asyncIntSeen; // rising edge of the asynchronous pin
    logic                 coreRun;      // core and flash domains requested on
    logic                 periRun;      // peripheral domain requested on
    logic                 convRun;      // converter domain requested on
    logic                 asyRun;       // async timer domain requested on

    assign source = decodeSource(clock_source_select);
    assign mode = csc_pkg::csc_mode_t'(sleepMode);
    assign xtalSel = {1'b0, clock_source_select[0], startup_time_select};

    // time-out and stabilisation lengths per source and start-up select
    always_comb begin
        timeoutCycles = plainTimeout(startup_time_select);
        stabCycles = `CSC_STAB_EXT;
        case (source)
            csc_pkg::SRC_LOW_POWER_XTAL,
            csc_pkg::SRC_FULL_SWING_XTAL: begin
                // crystal table: low select bit and start-up select together
                case (xtalSel)
                    4'h0: begin
                        stabCycles = `CSC_STAB_258;
                        timeoutCycles = `CSC_TOUT_SHORT;
                    end
                    4'h1: begin
                        stabCycles = `CSC_STAB_258;
                        timeoutCycles = `CSC_TOUT_LONG;
                    end
                    4'h2: begin
                        stabCycles = `CSC_STAB_1K;
                        timeoutCycles = `CSC_TOUT_NONE;
                    end
                    4'h3: begin
                        stabCycles = `CSC_STAB_1K;
                        timeoutCycles = `CSC_TOUT_SHORT;
                    end
                    4'h4: begin
                        stabCycles = `CSC_STAB_1K;
                        timeoutCycles = `CSC_TOUT_LONG;
                    end
                    4'h5: begin
                        stabCycles = `CSC_STAB_16K;
                        timeoutCycles = `CSC_TOUT_NONE;
                    end
                    4'h6: begin
                        stabCycles = `CSC_STAB_16K;
                        timeoutCycles = `CSC_TOUT_SHORT;
                    end
                    default: begin
                        stabCycles = `CSC_STAB_16K;
                        timeoutCycles = `CSC_TOUT_LONG;
                    end
                endcase
            end
            csc_pkg::SRC_LOW_FREQ_XTAL: begin
                // slowest oscillator needs the longest settle
                stabCycles = `CSC_STAB_32K;
            end
            default: begin
                // rc oscillators and external clock settle fast
                stabCycles = `CSC_STAB_EXT;
            end
        endcase
    end

    // brown-out low holds reset like any other source
    assign resetCause = otherResetActive || (brownoutEnable && brownoutLow);

    // a zero time-out without brown-out protection is flagged to the system
    assign unsafeTimeout = (timeoutCycles == `CSC_TOUT_NONE) && !brownoutEnable;
    assign reservedSource = (source == csc_pkg::SRC_RESERVED);

    // asynchronous pin watched on the free-running clock, not the peripheral one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            asyncPin_q <= 1'b0;
        end else begin
            asyncPin_q <= asyncIntPin;
        end
    end
    assign asyncIntSeen = asyncIntPin && !asyncPin_q;

    // wake sources: pin, serial start and address match always, the rest qualified by which domains still run
    always_comb begin
        wakeEvent = asyncIntSeen;
        wakeEvent = wakeEvent || serialStartDetect || twoWireAddrMatch;
        if (periRun) begin
            // synchronous interrupts need the peripheral clock
            wakeEvent = wakeEvent || syncIntEvent;
        end
        if (asyRun) begin
            // real-time counter wake while asleep
            wakeEvent = wakeEvent || asyncTimerWake;
        end
        if (convRun) begin
            // conversion complete ends noise reduction sleep
            wakeEvent = wakeEvent || converterDone;
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        startTimeout = 1'b0;
        startStab = 1'b0;
        case (state_q)
            csc_pkg::ST_HOLD: begin
                // wait for every other reset source and a legal source
                if (!resetCause && !reservedSource) begin
                    state_d = csc_pkg::ST_TIMEOUT;
                    startTimeout = 1'b1;
                end
            end
            csc_pkg::ST_TIMEOUT: begin
                // time-out first, stabilisation after it
                if (resetCause) begin
                    state_d = csc_pkg::ST_HOLD;
                end else if (timeoutDone) begin
                    state_d = csc_pkg::ST_STABILISE;
                    startStab = 1'b1;
                end
            end
            csc_pkg::ST_STABILISE: begin
                // oscillator cycles counted before release
                if (resetCause) begin
                    state_d = csc_pkg::ST_HOLD;
                end else if (stabDone) begin
                    state_d = csc_pkg::ST_RUN;
                end
            end
            csc_pkg::ST_RUN: begin
                // enter sleep on request with a real sleep mode
                if (resetCause) begin
                    state_d = csc_pkg::ST_HOLD;
                end else if (sleepRequest && mode != csc_pkg::MODE_ACTIVE) begin
                    state_d = csc_pkg::ST_SLEEP;
                end
            end
            csc_pkg::ST_SLEEP: begin
                if (resetCause) begin
                    state_d = csc_pkg::ST_HOLD;
                end else if (wakeEvent) begin
                    if (mode == csc_pkg::MODE_POWER_SAVE ||
                        mode == csc_pkg::MODE_POWER_DOWN) begin
                        // oscillator was stopped: settle only, no time-out
                        state_d = csc_pkg::ST_STABILISE;
                        startStab = 1'b1;
                    end else begin
                        state_d = csc_pkg::ST_RUN;
                    end
                end
            end
            default: begin
                state_d = csc_pkg::ST_HOLD;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= csc_pkg::ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // remembers whether stabilisation belongs to a reset start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fromReset_q <= 1'b1;
        end else if (state_d == csc_pkg::ST_HOLD) begin
            fromReset_q <= 1'b1;
        end else if (state_d == csc_pkg::ST_RUN) begin
            fromReset_q <= 1'b0;
        end
    end

    // internal reset covers hold, time-out and post-reset stabilisation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            internalReset <= 1'b1;
        end else begin
            internalReset <= (state_d == csc_pkg::ST_HOLD) ||
                             (state_d == csc_pkg::ST_TIMEOUT) ||
                             (state_d == csc_pkg::ST_STABILISE && fromReset_q);
        end
    end

    // time-out counted on watchdog oscillator ticks
    csc_cycle_counter u_timeout (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (startTimeout),
        .target  (timeoutCycles),
        .tick    (watchdogOscTick),
        .done    (timeoutDone)
    );

    // stabilisation counted on the selected oscillator's ticks
    csc_cycle_counter u_stabilise (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (startStab),
        .target  (stabCycles),
        .tick    (oscTick),
        .done    (stabDone)
    );

    // system prescaler: every cycle, or one in eight when fuse is programmed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCount_q <= 3'h0;
        end else begin
            divCount_q <= divCount_q + 3'h1;
        end
    end
    assign systemTick = divide_by_eight_fuse || (divCount_q == `CSC_DIV8_LAST);

    // domain requests per state and sleep mode
    always_comb begin
        coreRun = (state_q == csc_pkg::ST_RUN);
        periRun = coreRun;
        convRun = coreRun;
        asyRun = coreRun && asyncTimerSelect;
        if (state_q == csc_pkg::ST_SLEEP) begin
            case (mode)
                csc_pkg::MODE_IDLE: begin
                    // only the core and flash domains stop
                    periRun = 1'b1;
                    convRun = 1'b1;
                    asyRun = asyncTimerSelect;
                end
                csc_pkg::MODE_ADC_NR: begin
                    // quiet digital logic while converting
                    convRun = 1'b1;
                    asyRun = asyncTimerSelect;
                end
                csc_pkg::MODE_POWER_SAVE,
                csc_pkg::MODE_EXT_STANDBY: begin
                    // real-time counter keeps counting
                    asyRun = asyncTimerSelect;
                end
                default: begin
                    // power-down and standby: everything halted
                    asyRun = 1'b0;
                end
            endcase
        end
    end

    // core domain gate, flash shares its request
    csc_domain_gate u_core_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .runReq   (coreRun),
        .tick     (systemTick),
        .domainEn (core_clock)
    );

    csc_domain_gate u_flash_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .runReq   (coreRun),
        .tick     (systemTick),
        .domainEn (flash_clock)
    );

    csc_domain_gate u_peri_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .runReq   (periRun),
        .tick     (systemTick),
        .domainEn (peripheral_clock)
    );

    csc_domain_gate u_conv_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .runReq   (convRun),
        .tick     (systemTick),
        .domainEn (converter_clock)
    );

    // async timer gate ignores the prescaler: its tick is held at one, so it follows asyRun every clk cycle
    csc_domain_gate u_asy_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .runReq   (asyRun),
        .tick     (1'b1),
        .domainEn (async_timer_clock)
    );

    // sleep status seen by the rest of the system
    assign sleeping = (state_q == csc_pkg::ST_SLEEP);

endmodule

// File: rtl/csc_cycle_counter.sv
// counts qualified ticks up to a loaded target and flags completion
// assumes tick is a one-cycle strobe synchronous to clk
`timescale 1ns/100ps
`include "csc_params.svh"

module csc_cycle_counter (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   start,
    input  wire logic [`CSC_CNT_W-1:0]  target,
    input  wire logic                   tick,
    output logic                        done
);

    logic [`CSC_CNT_W-1:0] count_q;     // ticks seen so far
    logic [`CSC_CNT_W-1:0] target_q;    // captured target
    logic                  busy_q;      // counting in progress

    // load on start, count ticks, stop at target
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q  <= '0;
            target_q <= '0;
            busy_q   <= 1'b0;
        end else if (start) begin
            count_q  <= '0;
            target_q <= target;
            busy_q   <= 1'b1;
        end else if (busy_q && count_q == target_q) begin
            busy_q <= 1'b0;
        end else if (busy_q && tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    // completion is seen while busy with the target reached
    assign done = busy_q && (count_q == target_q) && !start;

endmodule

// File: rtl/csc_domain_gate.sv
// glitch-free enable for one clock domain
// assumes the consumer gates its clock with this registered enable only
`timescale 1ns/100ps

module csc_domain_gate (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic runReq,
    input  wire logic tick,
    output logic      domainEn
);

    logic en_q;     // registered enable, changes only on a clock edge

    // enable is the request registered on a system tick, and low after every cycle without a tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= runReq & tick;
        end
    end

    assign domainEn = en_q;

endmodule

// File: tb/csc_clock_sva.sv
// assertions on the ports of the clock controller
// assumes fuses change only while sys_rst is high
`timescale 1ns/100ps
`include "csc_params.svh"
module csc_clock_sva (
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic [`CSC_SRC_SEL_W-1:0] clock_source_select,
    input wire logic [`CSC_SUT_W-1:0]     startup_time_select,
    input wire logic                      divide_by_eight_fuse,
    input wire logic                      otherResetActive,
    input wire logic                      brownoutEnable,
    input wire logic [`CSC_MODE_W-1:0]    sleepMode,
    input wire logic                      internalReset,
    input wire logic                      core_clock,
    input wire logic                      flash_clock,
    input wire logic                      peripheral_clock,
    input wire logic                      systemTick,
    input wire logic                      sleeping,
    input wire logic                      reservedSource,
    input wire logic                      unsafeTimeout
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic toutZero; // selected time-out is zero cycles, low-power and full-swing crystals use the joint table
    assign toutZero = (clock_source_select[3] || clock_source_select[3:1] == 3'h3)
        ? ({clock_source_select[0], startup_time_select} inside {3'h2, 3'h5})
        : (startup_time_select == 2'h0);
    sequence s_gap; (!systemTick) [*7] ##1 systemTick; endsequence
    sequence s_nap; sleeping && $past(sleeping); endsequence
    property p_rst; $fell(sys_rst) |-> internalReset && !core_clock && !peripheral_clock; endproperty
    property p_hold; otherResetActive |=> internalReset; endproperty
    property p_core; internalReset && $past(internalReset) |-> !core_clock; endproperty
    property p_flash; flash_clock == core_clock; endproperty
    property p_resv; reservedSource == (clock_source_select == 4'h1); endproperty
    property p_unsafe; !reservedSource |-> unsafeTimeout == (toutZero && !brownoutEnable); endproperty
    property p_div; !divide_by_eight_fuse && systemTick |=> s_gap; endproperty
    property p_full; divide_by_eight_fuse |-> systemTick; endproperty
    property p_slp; s_nap |-> !core_clock; endproperty
    property p_wake; sleeping |-> !internalReset; endproperty
    property p_pd; s_nap and sleepMode == csc_pkg::MODE_POWER_DOWN |-> !peripheral_clock; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_hold: assert property (p_hold) else $error("reset cause ignored");
    a_core: assert property (p_core) else $error("core runs in reset");
    a_flash: assert property (p_flash) else $error("flash apart from core");
    a_resv: assert property (p_resv) else $error("reserved flag wrong");
    a_unsafe: assert property (p_unsafe) else $error("unsafe flag wrong");
    a_div: assert property (p_div) else $error("divide by eight wrong");
    a_full: assert property (p_full) else $error("undivided tick missing");
    a_slp: assert property (p_slp) else $error("core runs asleep");
    a_wake: assert property (p_wake) else $error("reset while asleep");
    a_pd: assert property (p_pd) else $error("peripheral runs in power-down");
endmodule
bind csc_clock_control csc_clock_sva csc_clock_sva_inst (.clk, .sys_rst, .clock_source_select,
    .startup_time_select, .divide_by_eight_fuse, .otherResetActive, .brownoutEnable, .sleepMode,
    .internalReset, .core_clock, .flash_clock, .peripheral_clock, .systemTick, .sleeping,
    .reservedSource, .unsafeTimeout);

// File: tb/csc_osc_model.sv
// oscillator model: watchdog and selected oscillator strobes
// assumes clk is the system clock; slow spaces ticks three cycles apart
`timescale 1ns/100ps
module csc_osc_model (
    input  wire logic clk,
    input  wire logic slow,
    output logic      oscTick = 1'h0,
    output logic      watchdogOscTick = 1'h0
);
    logic [1:0] phase_q = 2'h0; // spacing of slow ticks
    // one strobe per oscillator cycle, moved off the sampling edge
    always @(negedge clk) begin
        phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
        oscTick <= !slow || (phase_q == 2'h0);
        watchdogOscTick <= !slow || (phase_q == 2'h0);
    end
endmodule

// File: tb/tb_top.sv
// self-checking bench: start-up lengths per fuse row, reserved source, sleep and wake
// assumes the oscillator model ticks every cycle unless slow is set
`timescale 1ns/100ps
module tb_top;
    localparam int NR = 9;
    logic clk = 1'h0, sys_rst = 1'h1, div = 1'h0, other = 1'h0, bodEn = 1'h0, bodLow = 1'h0;
    logic slow = 1'h0, slpReq = 1'h0, aPin = 1'h0, sInt = 1'h0, ser = 1'h0;
    logic [3:0] sel = 4'h2;
    logic [1:0] sut = 2'h2;
    logic [2:0] mode = 3'h0;
    logic oscTick, wdTick, iRst, coreClk, flashClk, perClk, asyClk, adcClk, sTick, slp, resv, unsafe;
    int failures = 0, cmp_count = 0, base, d, dIdle;
    // fuse rows: source, start-up, hold cycles, cycles beyond the first row
    logic [3:0] rS [NR] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'h8, 4'hE, 4'h9, 4'h3, 4'h6};
    logic [1:0] rU [NR] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
    int rH [NR] = '{0, 0, 0, 0, 0, 0, 0, 40, 30};
    int rE [NR] = '{0, 512, 8192, 32762, 764, 1018, 16378, 40, 794};
    logic [NR-1:0] rD = 9'h1FB, rB = 9'h100, rZ = 9'h0E9; // divide, brown-out, unsafe per row
    always #5 clk = ~clk;
    csc_osc_model csc_osc_model_inst (.clk(clk), .slow(slow), .oscTick(oscTick),
        .watchdogOscTick(wdTick));
    csc_clock_control csc_clock_control_inst (.clk(clk), .sys_rst(sys_rst),
        .clock_source_select(sel), .startup_time_select(sut), .divide_by_eight_fuse(div),
        .otherResetActive(other), .brownoutEnable(bodEn), .brownoutLow(bodLow),
        .watchdogOscTick(wdTick), .oscTick(oscTick), .sleepMode(mode), .sleepRequest(slpReq),
        .asyncTimerSelect(slow), .asyncIntPin(aPin), .syncIntEvent(sInt),
        .serialStartDetect(ser), .twoWireAddrMatch(1'h0), .asyncTimerWake(1'h0),
        .converterDone(1'h0), .internalReset(iRst), .core_clock(coreClk), .flash_clock(flashClk),
        .peripheral_clock(perClk), .async_timer_clock(asyClk), .converter_clock(adcClk),
        .systemTick(sTick), .sleeping(slp), .reservedSource(resv), .unsafeTimeout(unsafe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? iRst : (w == 1) ? slp : (w == 2) ? coreClk : perClk;
    endfunction
    // bounded wait on one output, n counts falling edges passed
    task automatic wait_for(input int w, input logic v, output int n);
        for (n = 0; pick(w) !== v; n++) begin
            if (n > 50000) begin
                failures++;
                complete_run();
            end
            @(negedge clk);
        end
    endtask
    // reset with new fuses, hold a reset cause h cycles, time the release
    task automatic boot(input int i, output int n);
        @(negedge clk);
        sys_rst = 1'h1;
        sel = rS[i];
        sut = rU[i];
        div = rD[i];
        bodEn = rB[i];
        other = !rB[i] && rH[i] > 0;
        bodLow = rB[i] && rH[i] > 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'h0;
        repeat (rH[i]) @(negedge clk);
        other = 1'h0;
        bodLow = 1'h0;
        if (!resv) wait_for(0, 1'h0, n);
        n = n + rH[i];
    endtask
    // sleep in mode m, wake by interrupt, time wake to core clock
    task automatic nap(input logic [2:0] m, output int n);
        mode = m;
        slpReq = 1'h1;
        @(negedge clk);
        slpReq = 1'h0;
        wait_for(1, 1'h1, n);
        if (m == csc_pkg::MODE_IDLE) wait_for(3, 1'h1, n);
        repeat (20) @(negedge clk);
        check({asyClk, adcClk, perClk, coreClk},
            {m != csc_pkg::MODE_POWER_DOWN, {2{m == csc_pkg::MODE_IDLE}}, 1'h0});
        if (m == csc_pkg::MODE_IDLE) sInt = 1'h1;
        else if (m == csc_pkg::MODE_POWER_SAVE) ser = 1'h1;
        else aPin = 1'h1;
        @(negedge clk);
        sInt = 1'h0;
        ser = 1'h0;
        wait_for(2, 1'h1, n);
        check(iRst, 1'h0);
        aPin = 1'h0;
    endtask
    initial begin
        for (int i = 0; i < NR; i++) begin
            boot(i, d);
            if (i == 0) base = d;
            check(32'(d - base), 32'(rE[i]));
            check(unsafe, rZ[i]);
            check(resv, 1'h0);
        end
        rS[0] = 4'h1;
        boot(0, d);
        repeat (200) @(negedge clk);
        check({resv, iRst}, 2'h3);
        rS[0] = 4'h8;
        boot(0, d);
        slow = 1'h1;
        nap(csc_pkg::MODE_IDLE, dIdle);
        nap(csc_pkg::MODE_POWER_DOWN, d);
        check(32'(d - dIdle > 700 && d - dIdle < 800), 32'h1);
        nap(csc_pkg::MODE_POWER_SAVE, d);
        complete_run();
    end
endmodule
